// ---- shared/ctw_pkg.sv ----
package ctw_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 20;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Control register fields
  localparam int CTRL_ACTIVE_REQ = 0;
  localparam int CTRL_TX_OFF = 1;
  localparam int CTRL_MANUAL_ON = 2;
  localparam int CTRL_OFFLINE_SEL = 3;
  localparam int CTRL_PN_ENABLE = 4;
  localparam int CTRL_SPLIT_ENABLE = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SUPPLY_OK = 2;
  localparam int STAT_WAKE = 3;
  localparam int STAT_FAULT = 4;

  // Transceiver mode codes
  localparam logic [1:0] MODE_OFFLINE = 2'h0;
  localparam logic [1:0] MODE_LISTEN = 2'h1;
  localparam logic [1:0] MODE_ONLINE = 2'h2;
  localparam logic [1:0] MODE_ACTIVE = 2'h3;

  // Chip system mode codes seen on sys_mode
  localparam logic [1:0] SYS_NORMAL = 2'h1;
  localparam logic [1:0] SYS_FLASH = 2'h2;

  // Wake-up message patterns
  localparam logic [3:0] INIT_LEN = 4'h7;
  localparam logic [55:0] INIT_PATTERN = 56'hC6EEEEEEEEEEEF;
  localparam logic [3:0] GLOBAL_LEN = 4'h8;
  localparam logic [63:0] GLOBAL_PATTERN = 64'hC6EEEEEEEEEEEE37;

  // Times in microseconds
  localparam int unsigned OFFLINE_SHORT_US = 50000;
  localparam int unsigned OFFLINE_LONG_US = 200000;
  localparam int unsigned OFFLINE_EXT_US = 1500000;
  localparam int unsigned GW_TIMEOUT_US = 100000;
  localparam int unsigned CLAMP_LOW_US = 2000;

  // Conventional wake filter phases
  typedef enum logic [1:0] {
    CTW_WF_IDLE,
    CTW_WF_DOM1,
    CTW_WF_REC1,
    CTW_WF_DOM2
  } ctw_wf_type;

endpackage

// ---- core/ctw_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Saturating up-counter with a run-time limit
module ctw_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic restart,
  input wire logic run,
  input wire logic [31:0] limit,
  // Result
  output logic expired
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic at_limit;

  // Stops at the limit so a long idle never wraps
  assign at_limit = (count_reg >= limit);
  assign count_next = restart ? 32'h0000_0000 :
                      (run && !at_limit) ? count_reg + 32'h0000_0001 :
                      count_reg;
  assign expired = at_limit && !restart;

  // Counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 32'h0000_0000;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

`default_nettype wire

// ---- core/ctw_ctrl.sv ----
// Behaviour
// - Supply regulator turns on on bus activity or when transceiver enabled.
// - Supply overload turns regulator off and is reported in status.
// - Manual supply-on bit powers the regulator regardless of the mode.
// - Start timeout or short: regulator off, ok cleared, tx off set, manual cleared.
// - Restart on tx-off clear in Active, wake, manual set, Active entry.
// - Four modes, current one shown in a two-bit status field.
// - Active only with active request and system mode Normal or Flash.
// - Entering Active switches the supply regulator on.
// - Transmitter-off in Active disables driver, receiver keeps working.
// - Leaving Active stops transmitter, watches wake, termination autonomous.
// - On-line: normal bias, transmitter off, receive pin low on wake.
// - On-line bus stuck dominant or recessive for off-line time: Off-line.
// - On-line Listen ignores all but global wake, receive pin high.
// - Off-line disables transceiver, terminates bus weakly to ground.
// - One control bit selects between two off-line times.
// - Entering On-line modes from Off-line uses the extended off-line time.
// - Conventional wake needs dominant, recessive, dominant, recessive.
// - Global wake filtering only with partial networking enabled.
// - Initial message data C6 EE EE EE EE EE EF recognised.
// - Global message C6 EE..EE 37 within timeout after initial wakes.
// - Listen entered from Off-line: global message alone within timeout.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module ctw_ctrl #(
  parameter int unsigned OFFLINE_SHORT_CYC =
    ctw_pkg::OFFLINE_SHORT_US * ctw_pkg::CLK_MHZ,
  parameter int unsigned OFFLINE_LONG_CYC =
    ctw_pkg::OFFLINE_LONG_US * ctw_pkg::CLK_MHZ,
  parameter int unsigned OFFLINE_EXT_CYC =
    ctw_pkg::OFFLINE_EXT_US * ctw_pkg::CLK_MHZ,
  parameter int unsigned GW_TIMEOUT_CYC =
    ctw_pkg::GW_TIMEOUT_US * ctw_pkg::CLK_MHZ,
  parameter int unsigned CLAMP_LOW_CYC =
    ctw_pkg::CLAMP_LOW_US * ctw_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip system mode, same clock
  input wire logic [1:0] sys_mode,
  // Microcontroller pins
  input wire logic transmit_pin,
  output logic receive_pin,
  // Bus front end
  input wire logic bus_dominant,
  output logic tx_drive_dominant,
  output logic transceiver_enable,
  output logic term_mid_en,
  output logic term_gnd_en,
  output logic split_en,
  // Received frames from the wake-up frame decoder
  input wire logic msg_valid,
  input wire logic [3:0] msg_len,
  input wire logic [63:0] msg_data,
  // Transceiver supply regulator
  input wire logic supply_good,
  output logic can_supply_regulator,
  // Wake request to the system controller
  output logic wake_req
);

  typedef enum logic [1:0] {
    CTW_ACTIVE,
    CTW_ONLINE,
    CTW_LISTEN,
    CTW_OFFLINE
  } ctw_mode_type;

  ctw_mode_type state_reg;
  ctw_mode_type state_next;

  // Pin synchronisers: bus level, transmit pin, supply comparator
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic dom_s;
  logic txd_s;
  logic good_s;
  logic dom_d_reg;
  logic bus_edge;

  // Control bits
  logic active_req_reg;
  logic tx_off_reg;
  logic tx_off_next;
  logic manual_reg;
  logic manual_next;
  logic offline_sel_reg;
  logic pn_en_reg;
  logic split_reg;

  // Status and supply state
  logic [1:0] transceiver_mode_status;
  logic supply_ok_status;
  logic ok_next;
  logic fault_reg;
  logic fault_next;
  logic fault_flag_reg;
  logic wake_flag_reg;
  logic reg_on_reg;
  logic reg_on_next;
  logic fault_evt;
  logic restart_evt;
  logic demand;

  // Wake logic
  ctw_pkg::ctw_wf_type wf_reg;
  ctw_pkg::ctw_wf_type wf_next;
  logic conv_wake;
  logic global_wake;
  logic wake_evt;
  logic init_match;
  logic global_match;
  logic gw_window_reg;
  logic gw_start;
  logic ext_reg;

  // Timers
  logic [31:0] offline_limit;
  logic offline_run;
  logic offline_exp;
  logic gw_exp;
  logic clamp_run;
  logic clamp_exp;

  // Bus decode
  logic setup_phase;
  logic wr_ctrl;
  logic wr_status;
  logic sel_ctrl;
  logic sel_status;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rd_next;
  logic [31:0] prdata_reg;

  // Output flops and combinational mode qualifiers
  logic rx_reg;
  logic tx_drv_reg;
  logic act_ok;
  logic is_online;

  // Two-flop synchronisers; only the second stage is used
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
      dom_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {transmit_pin, supply_good, bus_dominant};
      sync2_reg <= sync1_reg;
      dom_d_reg <= dom_s;
    end
  end

  assign dom_s = sync2_reg[0];
  assign good_s = sync2_reg[1];
  assign txd_s = sync2_reg[2];
  assign bus_edge = dom_s ^ dom_d_reg;

  // APB decode; a zero-wait slave with data loaded in setup
  assign setup_phase = psel && !penable;
  assign sel_ctrl = (paddr == ctw_pkg::ADDR_CTRL);
  assign sel_status = (paddr == ctw_pkg::ADDR_STATUS);
  assign wr_ctrl = psel && penable && pwrite && sel_ctrl;
  assign wr_status = psel && penable && pwrite && sel_status;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !sel_ctrl && !sel_status;
  assign prdata = prdata_reg;

  assign ctrl_word = {26'h000_0000, split_reg, pn_en_reg, offline_sel_reg,
                      manual_reg, tx_off_reg, active_req_reg};
  assign status_word = {27'h000_0000, fault_flag_reg, wake_flag_reg,
                        supply_ok_status, transceiver_mode_status};
  assign rd_next = sel_ctrl ? ctrl_word :
                   sel_status ? status_word : 32'h0000_0000;

  // Mode qualification and mode code
  assign act_ok = active_req_reg &&
                  (sys_mode == ctw_pkg::SYS_NORMAL ||
                   sys_mode == ctw_pkg::SYS_FLASH);
  assign is_online = (state_reg == CTW_ONLINE) ||
                     (state_reg == CTW_LISTEN);

  always_comb begin
    unique case (state_reg)
      CTW_ACTIVE: transceiver_mode_status = ctw_pkg::MODE_ACTIVE;
      CTW_ONLINE: transceiver_mode_status = ctw_pkg::MODE_ONLINE;
      CTW_LISTEN: transceiver_mode_status = ctw_pkg::MODE_LISTEN;
      CTW_OFFLINE: transceiver_mode_status = ctw_pkg::MODE_OFFLINE;
    endcase
  end

  // Mode transitions; Active always has priority when qualified
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CTW_ACTIVE: begin
        if (!act_ok) begin
          state_next = pn_en_reg ? CTW_LISTEN : CTW_ONLINE;
        end
      end
      CTW_ONLINE, CTW_LISTEN: begin
        if (act_ok) begin
          state_next = CTW_ACTIVE;
        end else if (offline_exp) begin
          state_next = CTW_OFFLINE;
        end else begin
          state_next = pn_en_reg ? CTW_LISTEN : CTW_ONLINE;
        end
      end
      CTW_OFFLINE: begin
        if (act_ok) begin
          state_next = CTW_ACTIVE;
        end else if (bus_edge) begin
          state_next = pn_en_reg ? CTW_LISTEN : CTW_ONLINE;
        end
      end
    endcase
  end

  // Off-line timer; bus edges restart it, extended limit after Off-line
  assign offline_run = is_online;
  assign offline_limit = ext_reg ? OFFLINE_EXT_CYC :
                         offline_sel_reg ? OFFLINE_LONG_CYC :
                         OFFLINE_SHORT_CYC;

  ctw_timer offline_timer (
    .clock(clock),
    .reset_n(reset_n),
    .restart(bus_edge || !offline_run),
    .run(offline_run),
    .limit(offline_limit),
    .expired(offline_exp)
  );

  // Conventional wake filter, off in Active and in Listen
  always_comb begin
    wf_next = wf_reg;
    conv_wake = 1'b0;
    if (state_reg == CTW_ACTIVE || state_reg == CTW_LISTEN ||
        pn_en_reg) begin
      wf_next = ctw_pkg::CTW_WF_IDLE;
    end else begin
      unique case (wf_reg)
        ctw_pkg::CTW_WF_IDLE: if (dom_s) wf_next = ctw_pkg::CTW_WF_DOM1;
        ctw_pkg::CTW_WF_DOM1: if (!dom_s) wf_next = ctw_pkg::CTW_WF_REC1;
        ctw_pkg::CTW_WF_REC1: if (dom_s) wf_next = ctw_pkg::CTW_WF_DOM2;
        ctw_pkg::CTW_WF_DOM2: begin
          if (!dom_s) begin
            wf_next = ctw_pkg::CTW_WF_IDLE;
            conv_wake = 1'b1;
          end
        end
      endcase
    end
  end

  // Global wake; the identifier is not looked at
  assign init_match = msg_valid && (msg_len == ctw_pkg::INIT_LEN) &&
                      (msg_data[63:8] == ctw_pkg::INIT_PATTERN);
  assign global_match = msg_valid && (msg_len == ctw_pkg::GLOBAL_LEN) &&
                        (msg_data == ctw_pkg::GLOBAL_PATTERN);
  assign global_wake = (state_reg == CTW_LISTEN) && gw_window_reg &&
                       !gw_exp && global_match;
  // Window opens on the initial message or on direct entry from Off-line
  assign gw_start = ((state_reg == CTW_LISTEN) && init_match) ||
                    ((state_reg == CTW_OFFLINE) &&
                     (state_next == CTW_LISTEN));
  assign wake_evt = conv_wake || global_wake;

  ctw_timer gw_timer (
    .clock(clock),
    .reset_n(reset_n),
    .restart(gw_start),
    .run(gw_window_reg),
    .limit(GW_TIMEOUT_CYC),
    .expired(gw_exp)
  );

  // Supply control: demand from any non-Off-line mode or manual bit
  assign demand = (state_next != CTW_OFFLINE) || manual_reg;
  assign clamp_run = reg_on_reg && !good_s && !supply_ok_status;

  ctw_timer clamp_timer (
    .clock(clock),
    .reset_n(reset_n),
    .restart(!clamp_run),
    .run(clamp_run),
    .limit(CLAMP_LOW_CYC),
    .expired(clamp_exp)
  );

  // Start timeout or collapse while up; both are overloads
  assign fault_evt = (clamp_run && clamp_exp) ||
                     (reg_on_reg && supply_ok_status && !good_s);
  assign restart_evt =
    (tx_off_reg && !tx_off_next && state_reg == CTW_ACTIVE) ||
    (wake_evt && state_reg != CTW_ACTIVE) ||
    (wr_ctrl && pwdata[ctw_pkg::CTRL_MANUAL_ON] && !manual_reg) ||
    (state_reg != CTW_ACTIVE && state_next == CTW_ACTIVE);
  assign fault_next = fault_evt ? 1'b1 :
                      restart_evt ? 1'b0 : fault_reg;
  assign reg_on_next = demand && !fault_next;
  assign ok_next = (fault_evt || !reg_on_reg) ? 1'b0 :
                   good_s ? 1'b1 : supply_ok_status;

  // Hardware update wins over a software write in the same cycle
  assign tx_off_next = fault_evt ? 1'b1 :
                       wr_ctrl ? pwdata[ctw_pkg::CTRL_TX_OFF] :
                       tx_off_reg;
  assign manual_next = fault_evt ? 1'b0 :
                       wr_ctrl ? pwdata[ctw_pkg::CTRL_MANUAL_ON] :
                       manual_reg;

  // Mode, filter and window state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CTW_OFFLINE;
      wf_reg <= ctw_pkg::CTW_WF_IDLE;
      gw_window_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wf_reg <= wf_next;
      gw_window_reg <= gw_start ||
                       (gw_window_reg && !gw_exp && !global_wake &&
                        state_next == CTW_LISTEN);
      ext_reg <= (state_reg == CTW_OFFLINE && state_next != CTW_OFFLINE &&
                  state_next != CTW_ACTIVE) ||
                 (ext_reg && state_next != CTW_OFFLINE &&
                  state_next != CTW_ACTIVE);
    end
  end

  // Control register; unwritten bits keep their value except tx-off and manual, which a fault sets and clears
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_req_reg <= ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_ACTIVE_REQ];
      offline_sel_reg <= ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_OFFLINE_SEL];
      pn_en_reg <= ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_PN_ENABLE];
      split_reg <= ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_SPLIT_ENABLE];
      tx_off_reg <= ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_TX_OFF];
      manual_reg <= ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_MANUAL_ON];
    end else begin
      tx_off_reg <= tx_off_next;
      manual_reg <= manual_next;
      if (wr_ctrl) begin
        active_req_reg <= pwdata[ctw_pkg::CTRL_ACTIVE_REQ];
        offline_sel_reg <= pwdata[ctw_pkg::CTRL_OFFLINE_SEL];
        pn_en_reg <= pwdata[ctw_pkg::CTRL_PN_ENABLE];
        split_reg <= pwdata[ctw_pkg::CTRL_SPLIT_ENABLE];
      end
    end
  end

  // Supply state and sticky flags; a new event beats a clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fault_reg <= 1'b0;
      reg_on_reg <= 1'b0;
      supply_ok_status <= 1'b0;
      fault_flag_reg <= 1'b0;
      wake_flag_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      reg_on_reg <= reg_on_next;
      supply_ok_status <= ok_next;
      fault_flag_reg <= fault_evt ||
        (fault_flag_reg && !(wr_status && pwdata[ctw_pkg::STAT_FAULT]));
      wake_flag_reg <= wake_evt ||
        (wake_flag_reg && !(wr_status && pwdata[ctw_pkg::STAT_WAKE]));
    end
  end

  // Pin-facing outputs and read data, all from flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_reg <= 1'b1;
      tx_drv_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      rx_reg <= (state_reg == CTW_ACTIVE) ? !dom_s :
                (state_reg == CTW_LISTEN) ? 1'b1 :
                !wake_flag_reg;
      tx_drv_reg <= (state_next == CTW_ACTIVE) && !tx_off_next &&
                    ok_next && !txd_s;
      if (setup_phase) begin
        prdata_reg <= rd_next;
      end
    end
  end

  // Front-end control; floating termination while the supply is faulted
  assign receive_pin = rx_reg;
  assign tx_drive_dominant = tx_drv_reg;
  assign transceiver_enable = (state_reg != CTW_OFFLINE);
  assign term_mid_en = (state_reg != CTW_OFFLINE) && !fault_reg;
  assign term_gnd_en = (state_reg == CTW_OFFLINE) && !fault_reg;
  assign split_en = split_reg && (state_reg == CTW_ONLINE ||
                                  state_reg == CTW_ACTIVE);
  assign can_supply_regulator = reg_on_reg;
  assign wake_req = wake_evt;

endmodule

`default_nettype wire

// ---- tb/ctw_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: the wired bus and the regulator output stage
module ctw_bus_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Bus drivers and level
  input wire logic bus_force,
  input wire logic tx_drive_dominant,
  output logic bus_dominant,
  // Regulator
  input wire logic can_supply_regulator,
  input wire logic short_supply,
  output logic supply_good
);
  logic [1:0] ramp_reg;
  // Dominant wins on the wired bus
  assign bus_dominant = bus_force | tx_drive_dominant;
  // Output needs three cycles to ramp; a short pulls it down at once
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ramp_reg <= 2'h0;
    end else if (!can_supply_regulator || short_supply) begin
      ramp_reg <= 2'h0;
    end else if (ramp_reg != 2'h3) begin
      ramp_reg <= ramp_reg + 2'h1;
    end
  end
  assign supply_good = ramp_reg == 2'h3 && !short_supply;
endmodule
`default_nettype wire

// ---- tb/ctw_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the transceiver controller
module ctw_ctrl_sva #(
  parameter int unsigned CLAMP_LOW_CYC = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  // Mode, pins and supply
  input wire logic [1:0] sys_mode,
  input wire logic tx_drive_dominant,
  input wire logic transceiver_enable,
  input wire logic term_mid_en,
  input wire logic term_gnd_en,
  input wire logic supply_good,
  input wire logic can_supply_regulator,
  input wire logic wake_req
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic [31:0] low_cnt;
  logic sys_ok;
  // Chip modes that allow the active transceiver
  assign sys_ok = sys_mode == ctw_pkg::SYS_NORMAL ||
    sys_mode == ctw_pkg::SYS_FLASH;
  // Length of the current on-but-not-good stretch
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 32'h0;
    end else if (can_supply_regulator && !supply_good) begin
      low_cnt <= low_cnt + 32'h1;
    end else begin
      low_cnt <= 32'h0;
    end
  end
  a_bad_addr: assert property (psel && penable &&
    paddr != ctw_pkg::ADDR_CTRL && paddr != ctw_pkg::ADDR_STATUS |-> pslverr)
    else $error("unmapped access without slave error");
  a_term_excl: assert property (!(term_mid_en && term_gnd_en))
    else $error("both terminations on");
  a_mid_needs_on: assert property (term_mid_en |-> transceiver_enable)
    else $error("mid termination while transceiver off");
  a_reg_on_entry: assert property ($rose(transceiver_enable) &&
    $past(term_gnd_en) |-> ##[0:2] can_supply_regulator)
    else $error("regulator not switched on");
  a_clamp_bound: assert property (low_cnt <= CLAMP_LOW_CYC + 5)
    else $error("regulator kept on without good supply");
  a_reg_drop_cause: assert property ($fell(can_supply_regulator) |->
    !transceiver_enable || !$past(supply_good, 2) ||
    !$past(supply_good, 3) || !$past(supply_good, 4) ||
    !$past(supply_good, 5))
    else $error("regulator dropped without cause");
  a_tx_sys_mode: assert property (tx_drive_dominant |-> sys_ok ||
    $past(sys_ok) || $past(sys_ok, 2) || $past(sys_ok, 3))
    else $error("transmitting outside normal or flash");
  a_tx_needs_on: assert property (tx_drive_dominant |-> transceiver_enable)
    else $error("transmitting while transceiver off");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  // Main scenarios reached
  c_wake: cover property ($rose(wake_req));
  c_fault: cover property ($fell(can_supply_regulator) && transceiver_enable);
  c_tx: cover property (tx_drive_dominant);
endmodule
bind ctw_ctrl ctw_ctrl_sva #(.CLAMP_LOW_CYC(CLAMP_LOW_CYC)) ctw_ctrl_sva_inst (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .sys_mode(sys_mode),
  .tx_drive_dominant(tx_drive_dominant),
  .transceiver_enable(transceiver_enable), .term_mid_en(term_mid_en),
  .term_gnd_en(term_gnd_en), .supply_good(supply_good),
  .can_supply_regulator(can_supply_regulator), .wake_req(wake_req));
`default_nettype wire

// ---- tb/ctw_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctw_ctrl_bench;
  localparam int OS = 20;
  localparam int OL = 40;
  localparam int OE = 80;
  localparam int CL = 10;
  logic clock, reset_n, psel, penable, pwrite, transmit_pin, msg_valid;
  logic bus_force, short_supply, err, pready, pslverr, receive_pin;
  logic tx_drive_dominant, transceiver_enable, term_mid_en, term_gnd_en;
  logic split_en, bus_dominant, supply_good, can_supply_regulator, wake_req;
  logic [1:0] sys_mode;
  logic [3:0] msg_len;
  logic [7:0] paddr;
  logic [15:0] lfsr = 16'h003D;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] msg_data;
  int n_checks = 0;
  int n_mismatch = 0;
  int n_wake = 0;
  int ew = 0;
  int n;
  ctw_ctrl #(.OFFLINE_SHORT_CYC(OS), .OFFLINE_LONG_CYC(OL),
    .OFFLINE_EXT_CYC(OE), .GW_TIMEOUT_CYC(30), .CLAMP_LOW_CYC(CL))
    ctw_ctrl_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_mode(sys_mode), .transmit_pin(transmit_pin),
    .receive_pin(receive_pin), .bus_dominant(bus_dominant),
    .tx_drive_dominant(tx_drive_dominant),
    .transceiver_enable(transceiver_enable), .term_mid_en(term_mid_en),
    .term_gnd_en(term_gnd_en), .split_en(split_en),
    .msg_valid(msg_valid), .msg_len(msg_len), .msg_data(msg_data),
    .supply_good(supply_good),
    .can_supply_regulator(can_supply_regulator), .wake_req(wake_req));
  ctw_bus_model ctw_bus_model_inst (.clock(clock), .reset_n(reset_n),
    .bus_force(bus_force), .tx_drive_dominant(tx_drive_dominant),
    .bus_dominant(bus_dominant),
    .can_supply_regulator(can_supply_regulator),
    .short_supply(short_supply), .supply_good(supply_good));
  // Free-running 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Accepted wake-ups, sampled before the edge updates land
  always @(posedge clock) begin
    if (wake_req === 1'b1) n_wake++;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  // One transfer; holds until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control write; random junk above the implemented bits
  task automatic wr(input logic [5:0] d);
    apb(1'b1, ctw_pkg::ADDR_CTRL, {rnd(), 10'h000, d});
  endtask
  task automatic rdst();
    apb(1'b0, ctw_pkg::ADDR_STATUS, 32'h0);
  endtask
  // Pairs of dominant and recessive bus phases
  task automatic dr(input int k);
    repeat (k) begin
      bus_force <= 1'b1;
      cyc(3);
      bus_force <= 1'b0;
      cyc(3);
    end
  endtask
  task automatic msg(input logic [3:0] l, input logic [63:0] d);
    @(posedge clock);
    msg_valid <= 1'b1;
    msg_len <= l;
    msg_data <= d;
    @(posedge clock);
    msg_valid <= 1'b0;
    msg_data <= {rnd(), rnd(), rnd(), rnd()};
  endtask
  // Waits for Off-line and checks the elapsed span against l
  task automatic offwait(input int l);
    n = 0;
    while (transceiver_enable === 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n + 4 >= l && n <= l + 8), 32'h1);
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard at 20000 cycles, far beyond the few hundred cycles needed
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
  initial begin
    {reset_n, psel, penable, pwrite, msg_valid, bus_force} = 6'h00;
    {short_supply, transmit_pin, sys_mode, msg_len, paddr} = 16'h4000;
    {pwdata, msg_data} = 96'h0;
    cyc(3);
    reset_n <= 1'b1;
    chk({transceiver_enable, term_gnd_en, receive_pin}, 3'h3);
    chk(can_supply_regulator, 1'b0);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, ctw_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    // Manual supply while off-line
    wr(6'h04);
    cyc(8);
    chk(can_supply_regulator, 1'b1);
    rdst();
    chk(rd, 32'h4);
    wr(6'h00);
    cyc(3);
    chk(can_supply_regulator, 1'b0);
    // Every chip mode with the active request set
    wr(6'h21);
    for (int s = 0; s < 4; s++) begin
      sys_mode <= 2'(s);
      cyc(5);
      rdst();
      chk(rd[1:0] == ctw_pkg::MODE_ACTIVE, s == 1 || s == 2);
      if (s == 1 || s == 2) chk({split_en, can_supply_regulator}, 2'h3);
    end
    sys_mode <= ctw_pkg::SYS_NORMAL;
    cyc(5);
    transmit_pin <= 1'b0;
    cyc(8);
    chk({tx_drive_dominant, receive_pin}, 2'h2);
    wr(6'h03);
    bus_force <= 1'b1;
    cyc(5);
    chk({tx_drive_dominant, receive_pin}, 2'h0);
    bus_force <= 1'b0;
    transmit_pin <= 1'b1;
    cyc(5);
    chk(receive_pin, 1'b1);
    // Supply short in Active, then recovery by software
    wr(6'h05);
    short_supply <= 1'b1;
    cyc(CL + 8);
    chk(can_supply_regulator, 1'b0);
    apb(1'b0, ctw_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h3);
    rdst();
    chk(rd[4:2], 3'h4);
    short_supply <= 1'b0;
    apb(1'b1, ctw_pkg::ADDR_STATUS, 32'h10);
    wr(6'h01);
    cyc(8);
    chk(can_supply_regulator, 1'b1);
    rdst();
    chk(rd[4:2], 3'h1);
    // Off-line time for both selections
    for (int s = 0; s < 2; s++) begin
      wr(6'h01);
      cyc(4);
      wr(s ? 6'h08 : 6'h00);
      offwait(s ? OL : OS);
    end
    // Conventional wake from Off-line
    dr(2);
    cyc(4);
    ew++;
    chk(n_wake, ew);
    chk(receive_pin, 1'b0);
    rdst();
    chk(rd[3:0], 4'hE);
    apb(1'b1, ctw_pkg::ADDR_STATUS, 32'h8);
    cyc(3);
    chk(receive_pin, 1'b1);
    dr(1);
    cyc(4);
    chk(n_wake, ew);
    offwait(OE);
    // Global wake filter in On-line Listen
    wr(6'h10);
    bus_force <= 1'b1;
    cyc(3);
    bus_force <= 1'b0;
    cyc(2);
    msg(4'h8, ctw_pkg::GLOBAL_PATTERN);
    cyc(4);
    ew++;
    chk(n_wake, ew);
    rdst();
    chk({receive_pin, rd[1:0]}, 3'h5);
    dr(2);
    cyc(4);
    chk(n_wake, ew);
    cyc(35);
    msg(4'h8, ctw_pkg::GLOBAL_PATTERN);
    cyc(4);
    chk(n_wake, ew);
    msg(4'h7, {ctw_pkg::INIT_PATTERN, 8'h00});
    msg(4'h8, ctw_pkg::GLOBAL_PATTERN);
    cyc(4);
    ew++;
    chk(n_wake, ew);
    dr(1);
    cyc(35);
    msg(4'h7, {ctw_pkg::INIT_PATTERN ^ 56'h1, 8'h00});
    msg(4'h8, ctw_pkg::GLOBAL_PATTERN);
    cyc(4);
    chk(n_wake, ew);
    results();
  end
endmodule
`default_nettype wire
